// ---- inc/wdc_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH
`define WDC_OFS_CTRL 8'h00
`define WDC_OFS_CAUSE 8'h04
`define WDC_OFS_KICK 8'h08
`define WDC_OFS_STAT 8'h0C
`define WDC_OFS_CLR 8'h10
`define WDC_OFS_IEN 8'h14
`define WDC_CTRL_RST 8'h00
`define WDC_CAUSE_BIT 3
`define WDC_EV_IRQ 0
`define WDC_EV_RST 1
`define WDC_SEL_MAX 4'h9
`define WDC_UNLOCK_CYC 3'h4
`define WDC_BASE_TICKS 2048
`define WDC_CLK_HZ 40000000
`define WDC_OSC_HZ 128000
`endif

// ---- inc/wdc_pkg.sv ----
// types shared by the watchdog control block
package wdc_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic irq_flag;
    logic irq_on;
    logic sel_hi;
    logic unlock;
    logic on;
    logic [2:0] sel_lo;
  } wdc_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wdc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wdc_apb_rsp_t;

endpackage

// ---- core/wdc_top.sv ----
// watchdog control with protected change window and apb registers
`timescale 1ns/1ps
`default_nettype none
`include "wdc_map.svh"

module wdc_top
  import wdc_pkg::*;
#(
  parameter int unsigned DIV = `WDC_CLK_HZ / `WDC_OSC_HZ,
  parameter int unsigned CNT_W = 21
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire wdc_apb_req_t apb_req_i,
  output wdc_apb_rsp_t apb_rsp_o,
  // fuse strap, high selects the higher level
  input wire logic safety_level_fuse_i,
  // watchdog reset request and interrupt
  output logic wdt_rst_o,
  output logic irq_o
);

  // ****************************************************
  // bus decode
  // ****************************************************
  wdc_ctrl_t ctrl_q;
  wdc_ctrl_t wd;
  wdc_ctrl_t ctrl_rd;
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic mapped;
  logic [2:0] win_q;
  logic win_open;
  logic unlock_wr;
  logic level2;
  logic on_rd;
  logic cause_q;
  logic [1:0] stat_q;
  logic [1:0] ien_q;
  logic [31:0] prdata_q;
  logic [3:0] sel_new;
  logic [3:0] sel_ok;
  logic [3:0] sel_q;

  assign acc = apb_req_i.psel && apb_req_i.penable;
  assign wr = acc && apb_req_i.pwrite;
  assign wr_ctrl = wr && (apb_req_i.paddr == `WDC_OFS_CTRL);
  assign wd = wdc_ctrl_t'(apb_req_i.pwdata[7:0]);
  assign level2 = safety_level_fuse_i;
  assign win_open = (win_q != 3'h0);
  assign unlock_wr = wr_ctrl && wd.unlock && wd.on;

  always_comb
  begin
    case (apb_req_i.paddr)
      `WDC_OFS_CTRL, `WDC_OFS_CAUSE, `WDC_OFS_KICK,
      `WDC_OFS_STAT, `WDC_OFS_CLR, `WDC_OFS_IEN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************
  // change window
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      win_q <= 3'h0;
    else if (unlock_wr)
      win_q <= `WDC_UNLOCK_CYC;
    else if (wr_ctrl && win_open)
      win_q <= 3'h0;
    else if (win_open)
      win_q <= win_q - 3'h1;
  end

  // ****************************************************
  // control register
  // ****************************************************
  logic running;
  logic to_q;
  logic rst_case;

  // reserved select codes fall back to the longest valid one
  assign sel_new = {wd.sel_hi, wd.sel_lo};
  assign sel_ok = (sel_new > `WDC_SEL_MAX) ? `WDC_SEL_MAX : sel_new;
  assign sel_q = {ctrl_q.sel_hi, ctrl_q.sel_lo};
  assign on_rd = ctrl_q.on || level2;
  assign running = on_rd || ctrl_q.irq_on;
  assign rst_case = to_q && !ctrl_q.irq_on && on_rd;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ctrl_q <= wdc_ctrl_t'(`WDC_CTRL_RST);
    else
    begin
      // flag: timeout sets, write one clears, set wins
      if (to_q && ctrl_q.irq_on)
        ctrl_q.irq_flag <= 1'b1;
      else if (wr_ctrl && wd.irq_flag)
        ctrl_q.irq_flag <= 1'b0;
      if (wr_ctrl)
        ctrl_q.irq_on <= wd.irq_on;
      else if (to_q && on_rd)
        ctrl_q.irq_on <= 1'b0;
      if (cause_q && !level2)
        ctrl_q.on <= 1'b1;
      else if (wr_ctrl && wd.on)
        ctrl_q.on <= 1'b1;
      else if (wr_ctrl && win_open && !level2)
        ctrl_q.on <= 1'b0;
      if (wr_ctrl && win_open)
      begin
        ctrl_q.sel_hi <= sel_ok[3];
        ctrl_q.sel_lo <= sel_ok[2:0];
      end
      ctrl_q.unlock <= 1'b0;
    end
  end

  always_comb
  begin
    ctrl_rd = ctrl_q;
    ctrl_rd.unlock = win_open;
    ctrl_rd.on = on_rd;
  end

  // ****************************************************
  // oscillator tick and timeout counter
  // ****************************************************
  logic [15:0] div_q;
  logic tick;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;
  logic to_raw;
  logic kick;

  assign tick = (div_q == 16'(DIV - 1));
  assign last = (CNT_W'(`WDC_BASE_TICKS) << sel_q) - CNT_W'(1);
  assign kick = wr && (apb_req_i.paddr == `WDC_OFS_KICK);
  assign to_raw = running && tick && (cnt_q == last);

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      div_q <= 16'h0000;
    else if (tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_q <= '0;
    else if (!running || kick)
      cnt_q <= '0;
    else if (tick)
      cnt_q <= (cnt_q == last) ? '0 : cnt_q + CNT_W'(1);
  end

  // timeout acts one cycle after detection
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      to_q <= 1'b0;
    else
      to_q <= to_raw;
  end

  // ****************************************************
  // reset request, cause flag, interrupt status
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      wdt_rst_o <= 1'b0;
    else
      wdt_rst_o <= rst_case;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cause_q <= 1'b0;
    else if (rst_case)
      cause_q <= 1'b1;
    else if (wr && (apb_req_i.paddr == `WDC_OFS_CAUSE)
             && !apb_req_i.pwdata[`WDC_CAUSE_BIT])
      cause_q <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      stat_q <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == `WDC_EV_IRQ) ? (to_q && ctrl_q.irq_on) : rst_case)
          stat_q[i] <= 1'b1;
        else if (wr && (apb_req_i.paddr == `WDC_OFS_CLR) && apb_req_i.pwdata[i])
          stat_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ien_q <= 2'h0;
    else if (wr && (apb_req_i.paddr == `WDC_OFS_IEN))
      ien_q <= apb_req_i.pwdata[1:0];
  end

  assign irq_o = |(stat_q & ien_q);

  // ****************************************************
  // read data, loaded in the setup cycle
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      prdata_q <= 32'h0000_0000;
    else if (apb_req_i.psel && !apb_req_i.penable)
    begin
      case (apb_req_i.paddr)
        `WDC_OFS_CTRL: prdata_q <= {24'h00_0000, ctrl_rd};
        `WDC_OFS_CAUSE: prdata_q <= 32'(cause_q) << `WDC_CAUSE_BIT;
        `WDC_OFS_STAT: prdata_q <= {30'h0, stat_q};
        `WDC_OFS_IEN: prdata_q <= {30'h0, ien_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    apb_rsp_o.prdata = prdata_q;
    apb_rsp_o.pready = 1'b1;
    apb_rsp_o.pslverr = acc && !mapped;
  end

  // ****************************************************
  // checks
  // ****************************************************
  a_disable_locked: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ctrl_q.on && wr_ctrl && !wd.on && !win_open |=> ctrl_q.on)
    else $error("enable cleared without open window");

  a_window_expiry: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    unlock_wr ##1 (!wr_ctrl) [*4] |=> !win_open)
    else $error("change window not closed after four cycles");

  a_window_open: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    unlock_wr ##1 (!wr_ctrl) [*3] |=> win_open)
    else $error("change window shorter than four cycles");

  a_sel_guard: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !win_open |=> $stable(sel_q))
    else $error("timeout select changed outside window");

  a_enable_free: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    wr_ctrl && wd.on |=> ctrl_rd.on)
    else $error("enable write of one ignored");

  a_level2_keep: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    level2 && $past(level2) |-> ctrl_rd.on && running)
    else $error("watchdog stopped in higher level");

  a_cause_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cause_q && !level2 |=> ctrl_q.on)
    else $error("enable not forced by cause flag");

  a_sel_clamp: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    sel_q <= `WDC_SEL_MAX)
    else $error("reserved timeout select stored");

  a_tick_spacing: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tick |=> (!tick) [*8])
    else $error("oscillator tick too frequent");

  a_irq_on_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    to_q && on_rd && !wr_ctrl |=> !ctrl_q.irq_on)
    else $error("irq enable kept after timeout");

  a_reset_path: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    to_raw && !ctrl_q.irq_on && on_rd && !wr_ctrl |=> ##1 wdt_rst_o ##1 cause_q)
    else $error("timeout did not request reset");

  a_window_close: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    wr_ctrl && win_open && !unlock_wr |=> !win_open)
    else $error("window left open after write");

endmodule

`default_nettype wire

// ---- testbench/wdc_top_tb_top.sv ----
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
`include "wdc_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module wdc_top_tb_top
  import wdc_pkg::*;
;
  typedef struct {logic [7:0] d; int gap; logic chk; logic [7:0] e;} wdc_row_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fuse = 1'b0;
  wdc_apb_req_t req = '0;
  wdc_apb_rsp_t rsp;
  logic wdt_rst;
  logic irq;
  logic [31:0] rd;
  logic err;
  int waited;
  int n_fail = 0;
  int checks_done = 0;
  // control writes: data, idle cycles after, readback flag, readback value
  wdc_row_t rows[13] = '{
    '{8'h08, 0, 1'b1, 8'h08},
    '{8'h00, 0, 1'b1, 8'h08},
    '{8'h2F, 0, 1'b1, 8'h08},
    '{8'h18, 0, 1'b0, 8'h00},
    '{8'h2F, 0, 1'b1, 8'h29},
    '{8'h00, 0, 1'b1, 8'h29},
    '{8'h18, 2, 1'b0, 8'h00},
    '{8'h00, 0, 1'b1, 8'h00},
    '{8'h08, 0, 1'b1, 8'h08},
    '{8'h18, 3, 1'b0, 8'h00},
    '{8'h00, 0, 1'b1, 8'h08},
    '{8'h18, 0, 1'b0, 8'h00},
    '{8'h00, 0, 1'b1, 8'h00}};

  wdc_top #(.DIV(9), .CNT_W(21)) dut (
    .core_clk_i(core_clk),
    .sys_rst_i(sys_rst),
    .apb_req_i(req),
    .apb_rsp_o(rsp),
    .safety_level_fuse_i(fuse),
    .wdt_rst_o(wdt_rst),
    .irq_o(irq)
  );

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ****************************************
  // bus and helper tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    @(posedge core_clk);
    while (rsp.pready !== 1'b1)
      @(posedge core_clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
  endtask

  task automatic idle(input int n);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h00_0000, e})
  endtask

  task automatic irqchk(input logic e);
    idle(1);
    @(negedge core_clk);
    `CHK(irq, e)
    @(posedge core_clk);
  endtask

  // waits for the reset pulse or the interrupt level
  task automatic wait_ev(input logic which);
    int k;
    idle(0);
    for (k = 0; k < 25000; k++)
    begin
      @(negedge core_clk);
      if ((which ? wdt_rst : irq) === 1'b1)
        break;
    end
    waited = k;
    `CHK(k < 25000, 1'b1)
    @(negedge core_clk);
    if (which)
      `CHK(wdt_rst, 1'b0)
    @(posedge core_clk);
  endtask

  task automatic do_reset();
    idle(0);
    sys_rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    do_reset();
    rdchk(`WDC_OFS_CTRL, `WDC_CTRL_RST);
    rdchk(`WDC_OFS_CAUSE, 8'h00);
    foreach (rows[i])
    begin
      apb(1'b1, `WDC_OFS_CTRL, rows[i].d);
      if (rows[i].chk)
        rdchk(`WDC_OFS_CTRL, rows[i].e);
      if (rows[i].gap > 0)
        idle(rows[i].gap);
    end
    apb(1'b1, 8'h18, 8'h01);
    `CHK(err, 1'b1)
    rdchk(8'h18, 8'h00);
    apb(1'b1, `WDC_OFS_IEN, 8'h01);
    apb(1'b1, `WDC_OFS_CTRL, 8'h40);
    wait_ev(1'b0);
    `CHK(waited > `WDC_BASE_TICKS*9-12 && waited < `WDC_BASE_TICKS*9+24, 1'b1)
    rdchk(`WDC_OFS_STAT, 8'h01);
    rdchk(`WDC_OFS_CTRL, 8'hC0);
    apb(1'b1, `WDC_OFS_CTRL, 8'hC0);
    rdchk(`WDC_OFS_CTRL, 8'h40);
    apb(1'b1, `WDC_OFS_IEN, 8'h00);
    irqchk(1'b0);
    apb(1'b1, `WDC_OFS_IEN, 8'h01);
    irqchk(1'b1);
    apb(1'b1, `WDC_OFS_CLR, 8'h01);
    irqchk(1'b0);
    apb(1'b1, `WDC_OFS_CTRL, 8'h48);
    apb(1'b1, `WDC_OFS_KICK, 8'h01);
    wait_ev(1'b0);
    rdchk(`WDC_OFS_CTRL, 8'h88);
    wait_ev(1'b1);
    rdchk(`WDC_OFS_STAT, 8'h03);
    rdchk(`WDC_OFS_CAUSE, 8'h08);
    apb(1'b1, `WDC_OFS_CTRL, 8'h18);
    apb(1'b1, `WDC_OFS_CTRL, 8'h00);
    apb(1'b0, `WDC_OFS_CTRL, 8'h00);
    `CHK(rd[3], 1'b1)
    apb(1'b1, `WDC_OFS_CAUSE, 8'h00);
    apb(1'b1, `WDC_OFS_CTRL, 8'h18);
    apb(1'b1, `WDC_OFS_CTRL, 8'h00);
    apb(1'b0, `WDC_OFS_CTRL, 8'h00);
    `CHK(rd[3], 1'b0)
    fuse <= 1'b1;
    do_reset();
    rdchk(`WDC_OFS_CTRL, 8'h08);
    apb(1'b1, `WDC_OFS_CTRL, 8'h18);
    apb(1'b1, `WDC_OFS_CTRL, 8'h03);
    rdchk(`WDC_OFS_CTRL, 8'h0B);
    idle(1);
    final_report();
  end

  // hang guard, well beyond three full timeouts
  initial
  begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
endmodule

`default_nettype wire
